// File: verilog/crf_regs.svh
// Purpose: constants of the core register file and flags
// Assumes: included by the register file only
// Notes: bit positions are those of the flags register
// Functional notes
// - eight identical 32-bit general registers
// - data access at 32, 16 or 8 bits
// - each register splits into extended, base halves
// - base half splits into high, low bytes
// - each register's access width chosen independently
// - register seven doubles as stack pointer
// - 24-bit program counter holds next address
// - fetch address forces counter bit zero low
// - reset sequence loads counter from vector
// - reset sets mask bit; others cleared to zero
// - mask blocks interrupts except the non-maskable
// - any exception sequence sets the mask bit
// - flags load, store, and, or, xor
// - bits six and four are plain storage
// - byte arithmetic: half carry from bit 3
// - word arithmetic: half carry from bit 11
// - longword arithmetic: half carry from bit 27
// - negative flag takes result sign bit
// - branches use n z v c; some keep flags
// - zero flag set when result is zero
// - overflow flag set on arithmetic overflow
// - carry flag: carry, borrow, shift, bit accumulator
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH
`define CRF_FLAG_MASK 3'd7
`define CRF_FLAG_USER6 3'd6
`define CRF_FLAG_HALF 3'd5
`define CRF_FLAG_USER4 3'd4
`define CRF_FLAG_NEG 3'd3
`define CRF_FLAG_ZERO 3'd2
`define CRF_FLAG_OVF 3'd1
`define CRF_FLAG_CARRY 3'd0
`define CRF_MASK_RESET 1'b1
`define CRF_PC_RESET 24'h00_0000
`define CRF_STACK_INDEX 3'd7
`endif

// File: verilog/crf_pkg.sv
// Purpose: types of the core register file and flags
// Assumes: nothing
// Notes: codes are one-hot as the house style asks
package crf_pkg;
    // access width of a general register port
    typedef enum logic [3:0] {
        CRF_W_LONG = 4'b0001,
        CRF_W_EXT = 4'b0010,
        CRF_W_BHI = 4'b0100,
        CRF_W_BLO = 4'b1000
    } crf_width_t;
    // operation on the flags register
    typedef enum logic [6:0] {
        CRF_F_NONE = 7'b000_0001,
        CRF_F_LOAD = 7'b000_0010,
        CRF_F_AND = 7'b000_0100,
        CRF_F_OR = 7'b000_1000,
        CRF_F_XOR = 7'b001_0000,
        CRF_F_ARITH = 7'b010_0000,
        CRF_F_LOGIC = 7'b100_0000
    } crf_flag_op_t;
    // size of an arithmetic result
    typedef enum logic [2:0] {
        CRF_S_BYTE = 3'b001,
        CRF_S_WORD = 3'b010,
        CRF_S_LONG = 3'b100
    } crf_size_t;
endpackage

// File: verilog/crf_register_file.sv
// Purpose: general registers, program counter and flags register of the core
// Assumes: datapath computes results and carries; one clock, sync reset
// Notes: read ports combinational into flops are registered one cycle
`include "crf_regs.svh"

module crf_register_file
    import crf_pkg::*;
#(
    parameter int NUM_REGS = 8,
    parameter int REG_W = 32,
    parameter int PC_W = 24
) (
    input wire logic clock,
    input wire logic reset,
    // read port a
    input wire logic [2:0] rd_a_index,
    input wire crf_width_t rd_a_width,
    output logic [REG_W-1:0] rd_a_data,
    // read port b
    input wire logic [2:0] rd_b_index,
    input wire crf_width_t rd_b_width,
    output logic [REG_W-1:0] rd_b_data,
    // write port
    input wire logic wr_enable,
    input wire logic [2:0] wr_index,
    input wire crf_width_t wr_width,
    input wire logic [REG_W-1:0] wr_data,
    // stack pointer
    input wire logic sp_write,
    input wire logic [REG_W-1:0] sp_data,
    output logic [REG_W-1:0] stack_gp_reg,
    // program counter
    input wire logic reset_sequence,
    input wire logic [PC_W-1:0] reset_vector_data,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_data,
    output logic [PC_W-1:0] program_counter,
    output logic [PC_W-1:0] fetch_address,
    // flags
    input wire logic exception_start,
    input wire crf_flag_op_t flag_op,
    input wire logic [7:0] flag_operand,
    input wire crf_size_t arith_size,
    input wire logic [REG_W-1:0] result_data,
    input wire logic [REG_W-1:0] arith_a,
    input wire logic [REG_W-1:0] arith_b,
    input wire logic arith_subtract,
    input wire logic arith_extend,
    input wire logic arith_overflow,
    input wire logic arith_carry,
    input wire logic logic_carry,
    input wire logic logic_carry_write,
    output logic [7:0] flags_register,
    // interrupt gating
    input wire logic irq_request,
    input wire logic nmi_request,
    output logic irq_accept,
    output logic nmi_accept
);

    // ****************************************
    // storage
    // ****************************************
    logic [REG_W-1:0] wide_gp_reg [NUM_REGS];
    logic [REG_W-1:0] next_reg;
    logic [REG_W-1:0] next_sp;
    logic [7:0] next_flags;
    logic half_carry;
    logic [REG_W-1:0] sized_result;
    logic result_msb;
    logic result_zero;
    logic carry_in;
    logic [4:0] byte_low;
    logic [4:0] byte_low_sub;
    logic [12:0] word_low;
    logic [12:0] word_low_sub;
    logic [28:0] long_low;
    logic [28:0] long_low_sub;
    logic next_mask;
    logic [REG_W-1:0] rd_a_next;
    logic [REG_W-1:0] rd_b_next;

    // ****************************************
    // partial write merge
    // ****************************************
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input crf_width_t w,
                                               input logic [REG_W-1:0] d);
        logic [REG_W-1:0] r;
        r = old;
        unique case (w)
            CRF_W_LONG: r = d;
            CRF_W_EXT: r[31:16] = d[15:0];
            CRF_W_BHI: r[15:8] = d[7:0];
            CRF_W_BLO: r[7:0] = d[7:0];
            default: r = old;
        endcase
        return r;
    endfunction

    // reads return the selected slice right-aligned, upper bits zero
    function automatic logic [REG_W-1:0] pick(input logic [REG_W-1:0] v,
                                              input crf_width_t w);
        logic [REG_W-1:0] r;
        r = '0;
        unique case (w)
            CRF_W_LONG: r = v;
            CRF_W_EXT: r[15:0] = v[31:16];
            CRF_W_BHI: r[7:0] = v[15:8];
            CRF_W_BLO: r[7:0] = v[7:0];
            default: r = '0;
        endcase
        return r;
    endfunction

    // ****************************************
    // general registers
    // ****************************************
    // the base half of a full-width write is the low half of wr_data,
    // so a base-half write uses CRF_W_LONG on a merged value upstream;
    // here a base write is two byte writes, kept simple on purpose
    always_comb begin
        next_reg = merge(wide_gp_reg[wr_index], wr_width, wr_data);
        next_sp = sp_data;
    end

    // both read ports see the register as it stood before this edge
    always_comb begin
        rd_a_next = pick(wide_gp_reg[rd_a_index], rd_a_width);
        rd_b_next = pick(wide_gp_reg[rd_b_index], rd_b_width);
    end

    always_ff @(posedge clock) begin
        // general registers hold no reset value, like the hardware
        for (int i = 0; i < NUM_REGS; i++) begin
            if (wr_enable && wr_index == i[2:0]) begin
                wide_gp_reg[i] <= next_reg;
            end else if (sp_write && i[2:0] == `CRF_STACK_INDEX) begin
                wide_gp_reg[i] <= next_sp;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_a_data <= '0;
            rd_b_data <= '0;
            stack_gp_reg <= '0;
        end else begin
            rd_a_data <= rd_a_next;
            rd_b_data <= rd_b_next;
            stack_gp_reg <= wide_gp_reg[`CRF_STACK_INDEX];
        end
    end

    // ****************************************
    // program counter
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            program_counter <= `CRF_PC_RESET;
            fetch_address <= `CRF_PC_RESET;
        end else if (reset_sequence) begin
            program_counter <= reset_vector_data;
            fetch_address <= {reset_vector_data[PC_W-1:1], 1'b0};
        end else if (pc_load) begin
            program_counter <= pc_data;
            fetch_address <= {pc_data[PC_W-1:1], 1'b0};
        end
    end

    // ****************************************
    // arithmetic flag sources
    // ****************************************
    // carry into the low nibble only for the extend forms of byte arithmetic
    assign carry_in = arith_extend & flags_register[`CRF_FLAG_CARRY];

    // sums and differences of the bits below each half-carry point;
    // the top bit of each is the carry or borrow out of that point
    always_comb begin
        byte_low = 5'(arith_a[3:0]) + 5'(arith_b[3:0]) + 5'(carry_in);
        byte_low_sub = 5'(arith_a[3:0]) - 5'(arith_b[3:0]) - 5'(carry_in);
        word_low = 13'(arith_a[11:0]) + 13'(arith_b[11:0]);
        word_low_sub = 13'(arith_a[11:0]) - 13'(arith_b[11:0]);
        long_low = 29'(arith_a[27:0]) + 29'(arith_b[27:0]);
        long_low_sub = 29'(arith_a[27:0]) - 29'(arith_b[27:0]);
    end

    always_comb begin
        half_carry = 1'b0;
        sized_result = result_data;
        result_msb = result_data[31];
        unique case (arith_size)
            CRF_S_BYTE: begin
                half_carry = arith_subtract ? byte_low_sub[4] : byte_low[4];
                sized_result = {24'h00_0000, result_data[7:0]};
                result_msb = result_data[7];
            end
            CRF_S_WORD: begin
                // extend forms exist for bytes only, so no carry in here
                half_carry = arith_subtract ? word_low_sub[12] : word_low[12];
                sized_result = {16'h0000, result_data[15:0]};
                result_msb = result_data[15];
            end
            CRF_S_LONG: begin
                half_carry = arith_subtract ? long_low_sub[28] : long_low[28];
                sized_result = result_data;
                result_msb = result_data[31];
            end
            default: begin
                half_carry = 1'b0;
            end
        endcase
        result_zero = (sized_result == '0);
    end

    // ****************************************
    // flags register
    // ****************************************
    always_comb begin
        next_flags = flags_register;
        unique case (flag_op)
            CRF_F_NONE: next_flags = flags_register;
            CRF_F_LOAD: next_flags = flag_operand;
            CRF_F_AND: next_flags = flags_register & flag_operand;
            CRF_F_OR: next_flags = flags_register | flag_operand;
            CRF_F_XOR: next_flags = flags_register ^ flag_operand;
            CRF_F_ARITH: begin
                next_flags[`CRF_FLAG_HALF] = half_carry;
                next_flags[`CRF_FLAG_NEG] = result_msb;
                next_flags[`CRF_FLAG_ZERO] = result_zero;
                next_flags[`CRF_FLAG_OVF] = arith_overflow;
                next_flags[`CRF_FLAG_CARRY] = arith_carry;
            end
            CRF_F_LOGIC: begin
                next_flags[`CRF_FLAG_NEG] = result_msb;
                next_flags[`CRF_FLAG_ZERO] = result_zero;
                next_flags[`CRF_FLAG_OVF] = 1'b0;
            end
            default: next_flags = flags_register;
        endcase
        // bit accumulator writes from bit-manipulation instructions
        if (logic_carry_write) begin
            next_flags[`CRF_FLAG_CARRY] = logic_carry;
        end
    end

    // ****************************************
    // interrupt mask
    // ****************************************
    // exception entry overrides a same-cycle clear of the mask,
    // so no handler ever starts with interrupts open
    always_comb begin
        next_mask = next_flags[`CRF_FLAG_MASK];
        if (exception_start || reset_sequence) begin
            next_mask = `CRF_MASK_RESET;
        end
    end

    // the mask bit resets to one; the rest reset to zero in the block below
    always_ff @(posedge clock) begin
        if (reset) begin
            flags_register[`CRF_FLAG_MASK] <= `CRF_MASK_RESET;
        end else begin
            flags_register[`CRF_FLAG_MASK] <= next_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            // kept defined for simulation; software must not rely on it
            flags_register[6:0] <= 7'h00;
        end else begin
            flags_register[6:0] <= next_flags[6:0];
        end
    end

    // ****************************************
    // interrupt gating
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_accept <= 1'b0;
            nmi_accept <= 1'b0;
        end else begin
            irq_accept <= irq_request && !next_mask;
            nmi_accept <= nmi_request;
        end
    end

endmodule

// File: sim/crf_register_file_monitor.sv
// Purpose: port checks of the core register file
// Assumes: one clock, sync active-high reset
// Notes: bound into every crf_register_file
module crf_register_file_monitor
    import crf_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic reset_sequence,
    input wire logic [23:0] reset_vector_data,
    input wire logic pc_load,
    input wire logic [23:0] pc_data,
    input wire logic [23:0] program_counter,
    input wire logic [23:0] fetch_address,
    input wire logic exception_start,
    input wire crf_flag_op_t flag_op,
    input wire logic [7:0] flag_operand,
    input wire logic logic_carry_write,
    input wire logic logic_carry,
    input wire logic [7:0] flags_register,
    input wire logic irq_accept,
    input wire logic nmi_request,
    input wire logic nmi_accept
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // mask set wins over flag writes
    sequence s_quiet;
        !exception_start && !reset_sequence && !logic_carry_write;
    endsequence
    property p_fetch;
        fetch_address == {program_counter[23:1], 1'b0};
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch bit");
    property p_vec;
        reset_sequence |=> program_counter == $past(reset_vector_data) && flags_register[7];
    endproperty
    a_vec: assert property (p_vec) else $error("reset load");
    property p_pc;
        pc_load && !reset_sequence |=> program_counter == $past(pc_data);
    endproperty
    a_pc: assert property (p_pc) else $error("pc load");
    property p_exc;
        exception_start |=> flags_register[7];
    endproperty
    a_exc: assert property (p_exc) else $error("mask set");
    property p_irq;
        irq_accept |-> !flags_register[7];
    endproperty
    a_irq: assert property (p_irq) else $error("irq masked");
    property p_nmi;
        nmi_request |=> nmi_accept;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lost");
    property p_load;
        flag_op == CRF_F_LOAD ##0 s_quiet |=> flags_register == $past(flag_operand);
    endproperty
    a_load: assert property (p_load) else $error("flag load");
    property p_lcw;
        logic_carry_write && !reset_sequence |=> flags_register[0] == $past(logic_carry);
    endproperty
    a_lcw: assert property (p_lcw) else $error("carry write");
endmodule
bind crf_register_file crf_register_file_monitor u_mon (.clock, .reset, .reset_sequence,
    .reset_vector_data, .pc_load, .pc_data, .program_counter, .fetch_address,
    .exception_start, .flag_op, .flag_operand, .logic_carry_write, .logic_carry,
    .flags_register, .irq_accept, .nmi_request, .nmi_accept);

// File: sim/crf_datapath_model.sv
// Purpose: behavioural datapath feeding results and carries
// Assumes: operands held while flag_op is arithmetic
// Notes: answers at once; no faults injected
module crf_datapath_model
    import crf_pkg::*;
(
    input wire logic [31:0] arith_a,
    input wire logic [31:0] arith_b,
    input wire logic arith_subtract,
    input wire crf_size_t arith_size,
    output logic [31:0] result_data,
    output logic arith_carry,
    output logic arith_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        int w;
        logic [32:0] m;
        logic [32:0] s;
        w = (arith_size == CRF_S_BYTE) ? 8 : (arith_size == CRF_S_WORD) ? 16 : 32;
        m = (33'h1 << w) - 33'h1;
        // borrow wraps, so bit w doubles as borrow
        s = arith_subtract ? ({1'b0, arith_a} & m) - ({1'b0, arith_b} & m)
                           : ({1'b0, arith_a} & m) + ({1'b0, arith_b} & m);
        result_data = s[31:0] & m[31:0];
        arith_carry = s[w];
        arith_overflow = (arith_a[w-1] ^ s[w-1]) & (arith_a[w-1] ^ arith_b[w-1] ^ ~arith_subtract);
    end
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench of the core register file
// Assumes: datapath model drives results and carries
// Notes: read port a fixed on register 3
module tb_top
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset = 1'b1, wr_enable = 1'b0, sp_write = 1'b0, pc_load = 1'b0;
    logic reset_sequence = 1'b0, exception_start = 1'b0, arith_subtract = 1'b0;
    logic logic_carry = 1'b0, logic_carry_write = 1'b0, irq_request = 1'b0, nmi_request = 1'b0;
    logic irq_accept, nmi_accept, arith_carry, arith_overflow;
    logic arith_extend = 1'b0;
    logic [2:0] rd_b_index = 3'h0, wr_index = 3'h0;
    crf_width_t rd_b_width = CRF_W_LONG, wr_width = CRF_W_LONG;
    crf_flag_op_t flag_op = CRF_F_NONE;
    crf_size_t arith_size = CRF_S_BYTE;
    logic [31:0] wr_data = 32'h0, sp_data = 32'h0, arith_a = 32'h0, arith_b = 32'h0;
    logic [31:0] rd_a_data, rd_b_data, stack_gp_reg, result_data;
    logic [23:0] reset_vector_data = 24'h0, pc_data = 24'h0, program_counter, fetch_address;
    logic [7:0] flag_operand = 8'h0, flags_register;
    int num_errors = 0, compares = 0;
    crf_register_file dut (.clock, .reset, .rd_a_index(3'h3), .rd_a_width(CRF_W_LONG),
        .rd_a_data, .rd_b_index, .rd_b_width, .rd_b_data, .wr_enable, .wr_index, .wr_width,
        .wr_data, .sp_write, .sp_data, .stack_gp_reg, .reset_sequence, .reset_vector_data,
        .pc_load, .pc_data, .program_counter, .fetch_address, .exception_start, .flag_op,
        .flag_operand, .arith_size, .result_data, .arith_a, .arith_b, .arith_subtract,
        .arith_extend, .arith_overflow, .arith_carry, .logic_carry, .logic_carry_write,
        .flags_register, .irq_request, .nmi_request, .irq_accept, .nmi_accept);
    crf_datapath_model u_dp (.arith_a, .arith_b, .arith_subtract, .arith_size,
        .result_data, .arith_carry, .arith_overflow);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] i, input crf_width_t w, input logic [31:0] d);
        @(posedge clock);
        wr_enable <= 1'b1;
        wr_index <= i;
        wr_width <= w;
        wr_data <= d;
        @(posedge clock);
        wr_enable <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] i, input crf_width_t w, input logic [31:0] e);
        @(posedge clock);
        rd_b_index <= i;
        rd_b_width <= w;
        repeat (2) @(posedge clock);
        #1;
        check(rd_b_data, e);
    endtask
    // flag op then settle one edge
    task automatic fop(input crf_flag_op_t op, input logic [7:0] v, input logic [7:0] e);
        @(posedge clock);
        flag_op <= op;
        flag_operand <= v;
        @(posedge clock);
        flag_op <= CRF_F_NONE;
        #1;
        check(32'(flags_register), 32'(e));
    endtask
    // e holds H,N,Z,V,C
    task automatic ar(input crf_size_t s, input logic sb, input logic [31:0] a,
                      input logic [31:0] b, input logic [4:0] e);
        @(posedge clock);
        flag_op <= CRF_F_ARITH;
        arith_size <= s;
        arith_subtract <= sb;
        arith_a <= a;
        arith_b <= b;
        @(posedge clock);
        flag_op <= CRF_F_NONE;
        #1;
        check(32'({flags_register[5], flags_register[3:0]}), 32'(e));
    endtask
    initial begin
        #200_000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        check(32'(flags_register[7]), 32'h1);
        for (int i = 0; i < 8; i++) wr(3'(i), CRF_W_LONG, 32'(i) * 32'h1111_1111);
        for (int i = 0; i < 8; i++) rd(3'(i), CRF_W_LONG, 32'(i) * 32'h1111_1111);
        check(stack_gp_reg, 32'h7777_7777);
        wr(3'h3, CRF_W_EXT, 32'h0000_AABB);
        wr(3'h3, CRF_W_BHI, 32'h0000_00CC);
        wr(3'h3, CRF_W_BLO, 32'h0000_00DD);
        rd(3'h3, CRF_W_LONG, 32'hAABB_CCDD);
        rd(3'h3, CRF_W_EXT, 32'h0000_AABB);
        rd(3'h3, CRF_W_BHI, 32'h0000_00CC);
        rd(3'h3, CRF_W_BLO, 32'h0000_00DD);
        rd(3'h2, CRF_W_LONG, 32'h2222_2222);
        check(rd_a_data, 32'hAABB_CCDD);
        @(posedge clock);
        sp_write <= 1'b1;
        sp_data <= 32'h0000_FFF0;
        @(posedge clock);
        sp_write <= 1'b0;
        rd(3'h7, CRF_W_LONG, 32'h0000_FFF0);
        check(stack_gp_reg, 32'h0000_FFF0);
        @(posedge clock);
        reset_sequence <= 1'b1;
        reset_vector_data <= 24'h12_3457;
        @(posedge clock);
        reset_sequence <= 1'b0;
        pc_load <= 1'b1;
        pc_data <= 24'h00_0ABD;
        #1;
        check(32'(program_counter), 32'h0012_3457);
        check(32'(fetch_address), 32'h0012_3456);
        @(posedge clock);
        pc_load <= 1'b0;
        #1;
        check(32'(program_counter), 32'h0000_0ABD);
        fop(CRF_F_LOAD, 8'h50, 8'h50);
        irq_request <= 1'b1;
        nmi_request <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(32'(irq_accept), 32'h1);
        exception_start <= 1'b1;
        @(posedge clock);
        exception_start <= 1'b0;
        @(posedge clock);
        #1;
        check(32'(flags_register), 32'h0000_00D0);
        check(32'({irq_accept, nmi_accept}), 32'h1);
        fop(CRF_F_AND, 8'h7F, 8'h50);
        fop(CRF_F_OR, 8'h0F, 8'h5F);
        fop(CRF_F_XOR, 8'hFF, 8'hA0);
        ar(CRF_S_BYTE, 1'b0, 32'h0000_000F, 32'h0000_0001, 5'h10);
        ar(CRF_S_BYTE, 1'b1, 32'h0000_0010, 32'h0000_0001, 5'h10);
        ar(CRF_S_BYTE, 1'b0, 32'h0000_0080, 32'h0000_0080, 5'h07);
        ar(CRF_S_BYTE, 1'b0, 32'h0000_0070, 32'h0000_0010, 5'h0A);
        ar(CRF_S_WORD, 1'b0, 32'h0000_0F00, 32'h0000_0100, 5'h10);
        ar(CRF_S_WORD, 1'b0, 32'h0000_0001, 32'h0000_0001, 5'h00);
        ar(CRF_S_LONG, 1'b0, 32'h7FFF_FFFF, 32'h0000_0001, 5'h1A);
        @(posedge clock);
        logic_carry_write <= 1'b1;
        logic_carry <= 1'b1;
        @(posedge clock);
        logic_carry_write <= 1'b0;
        #1;
        check(32'(flags_register[0]), 32'h1);
        arith_extend <= 1'b1;
        ar(CRF_S_BYTE, 1'b0, 32'h0000_000F, 32'h0000_0000, 5'h10);
        fop(CRF_F_LOAD, 8'h2F, 8'h2F);
        fop(CRF_F_LOGIC, 8'h00, 8'h21);
        print_verdict();
    end
endmodule
